// File: hdl/counter_core_pkg.sv
package counter_core_pkg;
	// ****************************************
	// CPU I/O locations (index on the byte bus)
	// ****************************************
	localparam logic [3:0] ADDR_CTRL_A = 4'h0;
	localparam logic [3:0] ADDR_CTRL_B = 4'h1;
	localparam logic [3:0] ADDR_CNT_LO = 4'h2;
	localparam logic [3:0] ADDR_CNT_HI = 4'h3;
	localparam logic [3:0] ADDR_CMPA_LO = 4'h4;
	localparam logic [3:0] ADDR_CMPA_HI = 4'h5;
	localparam logic [3:0] ADDR_CMPB_LO = 4'h6;
	localparam logic [3:0] ADDR_CMPB_HI = 4'h7;
	localparam logic [3:0] ADDR_CAP_LO = 4'h8;
	localparam logic [3:0] ADDR_CAP_HI = 4'h9;
	localparam logic [3:0] ADDR_STATUS = 4'hA;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CTRL_A_WAVE_LSB = 0;
	localparam int CTRL_B_SRC_LSB = 0;
	localparam int CTRL_B_WAVE_LSB = 3;
	localparam int STATUS_OVF_BIT = 0;

	// ****************************************
	// Count limits
	// ****************************************
	localparam logic [15:0] COUNT_FLOOR = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hFFFF;
	localparam logic [15:0] TOP_8BIT = 16'h00FF;
	localparam logic [15:0] TOP_9BIT = 16'h01FF;
	localparam logic [15:0] TOP_10BIT = 16'h03FF;
	localparam logic [15:0] COUNT_STEP = 16'h0001;

	// ****************************************
	// Values after reset
	// ****************************************
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [1:0] CTRL_A_RST = 2'h0;
	localparam logic [4:0] CTRL_B_RST = 5'h00;
	localparam logic FLOOR_RST = 1'b1;

	// ****************************************
	// Tick sources and prescaler taps
	// ****************************************
	localparam logic [2:0] SRC_OFF = 3'h0;
	localparam logic [2:0] SRC_DIRECT = 3'h1;
	localparam logic [2:0] SRC_TAP_A = 3'h2;
	localparam logic [2:0] SRC_TAP_B = 3'h3;
	localparam logic [2:0] SRC_TAP_C = 3'h4;
	localparam logic [2:0] SRC_TAP_D = 3'h5;
	localparam logic [2:0] SRC_EXT_FALL = 3'h6;
	localparam logic [2:0] SRC_EXT_RISE = 3'h7;
	localparam int PRESCALE_W = 10;
	localparam logic [9:0] PRESCALE_RST = 10'h000;
	localparam logic [9:0] TAP_A_MASK = 10'h007;
	localparam logic [9:0] TAP_B_MASK = 10'h03F;
	localparam logic [9:0] TAP_C_MASK = 10'h0FF;
	localparam logic [9:0] TAP_D_MASK = 10'h3FF;

	// ****************************************
	// Counting behaviour classes
	// ****************************************
	typedef enum logic [1:0] {
		CLS_NORMAL = 2'b00,
		CLS_CLEAR = 2'b01,
		CLS_FAST = 2'b10,
		CLS_PHASE = 2'b11
	} count_class_e;
endpackage

// File: hdl/count_pin_sync.sv
`timescale 1ns/1ns
module count_pin_sync (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Raw pin
	input wire logic pin_in,
	// Edge pulses, one cycle each
	output logic pin_rise,
	output logic pin_fall
);
	import counter_core_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic rise;
		logic fall;
	} pin_s;

	pin_s st_r;
	pin_s st_nxt;

	// Level accepted only when second and third stage agree
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.rise = 1'b0;
		st_nxt.fall = 1'b0;
		if (st_r.s2 == st_r.s3) begin
			st_nxt.level = st_r.s3;
			st_nxt.rise = st_r.s3 & ~st_r.level;
			st_nxt.fall = ~st_r.s3 & st_r.level;
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (srst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pin_rise = st_r.rise;
	assign pin_fall = st_r.fall;

	// ****************************************
	// Checks
	// ****************************************
	property p_edge_single;
		@(posedge clock) disable iff (srst)
		pin_rise |=> !pin_rise && !pin_fall;
	endproperty
	a_edge_single: assert property (p_edge_single)
		else $error("edge pulse longer than one cycle");
endmodule

// File: hdl/counter_tick_source.sv
`timescale 1ns/1ns
module counter_tick_source (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Source choice
	input wire logic [2:0] clock_source_select,
	// Edges of the external count input
	input wire logic ext_rise,
	input wire logic ext_fall,
	// Single-cycle tick
	output logic timer_tick
);
	import counter_core_pkg::*;

	typedef struct packed {
		logic [PRESCALE_W-1:0] pre;
	} tick_s;

	tick_s st_r;
	tick_s st_nxt;

	// Tap fires when all its low prescaler bits are ones
	function automatic logic tap_hit(input logic [9:0] pre, input logic [9:0] mask);
		tap_hit = ((pre & mask) == mask);
	endfunction

	// Free-running prescaler shared by all taps
	always_comb begin
		st_nxt = st_r;
		st_nxt.pre = st_r.pre + 10'h001;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			st_r.pre <= PRESCALE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Source mux; select zero gives no ticks at all
	always_comb begin
		case (clock_source_select)
			SRC_OFF: timer_tick = 1'b0;
			SRC_DIRECT: timer_tick = 1'b1;
			SRC_TAP_A: timer_tick = tap_hit(st_r.pre, TAP_A_MASK);
			SRC_TAP_B: timer_tick = tap_hit(st_r.pre, TAP_B_MASK);
			SRC_TAP_C: timer_tick = tap_hit(st_r.pre, TAP_C_MASK);
			SRC_TAP_D: timer_tick = tap_hit(st_r.pre, TAP_D_MASK);
			SRC_EXT_FALL: timer_tick = ext_fall;
			SRC_EXT_RISE: timer_tick = ext_rise;
			default: timer_tick = 1'b0;
		endcase
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_no_source;
		@(posedge clock) disable iff (srst)
		(clock_source_select == SRC_OFF) |-> !timer_tick;
	endproperty
	a_no_source: assert property (p_no_source)
		else $error("tick with no source selected");

	property p_ext_rise;
		@(posedge clock) disable iff (srst)
		(clock_source_select == SRC_EXT_RISE) |-> (timer_tick == ext_rise);
	endproperty
	a_ext_rise: assert property (p_ext_rise)
		else $error("external rising edge tick mismatch");

	property p_tap_single;
		@(posedge clock) disable iff (srst)
		(clock_source_select == SRC_TAP_A) && timer_tick ##1
			(clock_source_select == SRC_TAP_A) |-> !timer_tick;
	endproperty
	a_tap_single: assert property (p_tap_single)
		else $error("prescaled tick not a single pulse");
endmodule

// File: hdl/sixteen_bit_counter_core.sv
`timescale 1ns/1ns
// Contract
// - Flag the floor whenever the count becomes zero.
// - All ones is the full-scale count value.
// - Ceiling is a fixed value, compare A or capture, by mode.
// - One shared 8-bit high-byte holding register for all 16-bit registers.
// - Low-byte write loads held high byte and written low byte together.
// - Count or capture low-byte read copies its high byte into the holding register.
// - Compare A and B reads return bytes directly, holding register untouched.
// - Count high-byte location reaches the holding register, not the counter.
// - Source select zero gives no ticks and stops the counter.
// - Count stays readable and writable with or without ticks.
// - CPU count write wins over a same-cycle clear or count.
// - Each tick clears, increments or decrements per the waveform mode.
// - Counting steps by exactly one; clear zeroes every bit.
// - Overflow flag set at the mode's point, usable as interrupt request.
// - External input ticks on rising edge for code 7, falling for 6.
module sixteen_bit_counter_core (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// CPU byte bus
	input wire logic [3:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	// Pins and neighbour units
	input wire logic external_count_input,
	input wire logic capture_load,
	// Values to compare, capture and waveform units
	output logic [15:0] count_value,
	output logic [15:0] compare_a_value,
	output logic [15:0] compare_b_value,
	output logic [15:0] capture_value,
	output logic [3:0] waveform_mode_select,
	output logic [2:0] clock_source_select,
	// Limit and event flags
	output logic count_floor,
	output logic overflow_flag
);
	import counter_core_pkg::*;

	typedef struct packed {
		logic [1:0] ctl_a;
		logic [4:0] ctl_b;
		logic [15:0] count;
		logic [15:0] cmp_a;
		logic [15:0] cmp_b;
		logic [15:0] cap;
		logic [7:0] temp;
		logic down;
		logic ovf;
		logic floor;
		logic [7:0] rdata;
	} core_s;

	core_s st_r;
	core_s st_nxt;
	logic timer_tick;
	logic ext_rise;
	logic ext_fall;
	logic cnt_wr;
	logic [15:0] top;
	count_class_e cls;

	// ****************************************
	// Mode decoding
	// ****************************************
	// Ceiling of the count sequence for a given mode
	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a,
		input logic [15:0] c);
		case (m)
			4'h1, 4'h5: top_of = TOP_8BIT;
			4'h2, 4'h6: top_of = TOP_9BIT;
			4'h3, 4'h7: top_of = TOP_10BIT;
			4'h4, 4'h9, 4'hB, 4'hF: top_of = a;
			4'h8, 4'hA, 4'hC, 4'hE: top_of = c;
			default: top_of = COUNT_MAX;
		endcase
	endfunction

	// How a tick moves the counter in a given mode
	function automatic count_class_e class_of(input logic [3:0] m);
		case (m)
			4'h0, 4'hD: class_of = CLS_NORMAL;
			4'h4, 4'hC: class_of = CLS_CLEAR;
			4'h5, 4'h6, 4'h7, 4'hE, 4'hF: class_of = CLS_FAST;
			default: class_of = CLS_PHASE;
		endcase
	endfunction

	assign waveform_mode_select = {st_r.ctl_b[CTRL_B_WAVE_LSB+1:CTRL_B_WAVE_LSB],
		st_r.ctl_a[CTRL_A_WAVE_LSB+1:CTRL_A_WAVE_LSB]};
	assign clock_source_select = st_r.ctl_b[CTRL_B_SRC_LSB+2:CTRL_B_SRC_LSB];

	// Mode selects ceiling and class
	always_comb begin
		top = top_of(waveform_mode_select, st_r.cmp_a, st_r.cap);
		cls = class_of(waveform_mode_select);
	end

	// ****************************************
	// Tick generation
	// ****************************************
	count_pin_sync u_pin_sync (
		.clock(clock),
		.srst(srst),
		.pin_in(external_count_input),
		.pin_rise(ext_rise),
		.pin_fall(ext_fall)
	);

	counter_tick_source u_tick_source (
		.clock(clock),
		.srst(srst),
		.clock_source_select(clock_source_select),
		.ext_rise(ext_rise),
		.ext_fall(ext_fall),
		.timer_tick(timer_tick)
	);

	// ****************************************
	// Counter, registers and byte access
	// ****************************************
	assign cnt_wr = io_wr && (io_addr == ADDR_CNT_LO);

	// Next state: count step, then CPU access on top
	always_comb begin
		st_nxt = st_r;
		// Software clear of overflow comes first so a same-cycle set wins
		if (io_wr && (io_addr == ADDR_STATUS) && io_wdata[STATUS_OVF_BIT]) begin
			st_nxt.ovf = 1'b0;
		end
		// A CPU count write discards the tick's operation
		if (timer_tick && !cnt_wr) begin
			case (cls)
				CLS_NORMAL: begin
					st_nxt.count = st_r.count + COUNT_STEP;
					if (st_r.count == COUNT_MAX) begin
						st_nxt.ovf = 1'b1;
					end
				end
				CLS_CLEAR: begin
					if (st_r.count == top) begin
						st_nxt.count = COUNT_FLOOR;
					end else begin
						st_nxt.count = st_r.count + COUNT_STEP;
					end
					if (st_r.count == COUNT_MAX) begin
						st_nxt.ovf = 1'b1;
					end
				end
				CLS_FAST: begin
					if (st_r.count == top) begin
						st_nxt.count = COUNT_FLOOR;
						st_nxt.ovf = 1'b1;
					end else begin
						st_nxt.count = st_r.count + COUNT_STEP;
					end
				end
				CLS_PHASE: begin
					// Turn at the ceiling and at zero; overflow marks the floor turn
					if (!st_r.down && (st_r.count >= top)) begin
						st_nxt.down = 1'b1;
						st_nxt.count = st_r.count - COUNT_STEP;
					end else if (st_r.down && (st_r.count == COUNT_FLOOR)) begin
						st_nxt.down = 1'b0;
						st_nxt.count = st_r.count + COUNT_STEP;
						st_nxt.ovf = 1'b1;
					end else if (st_r.down) begin
						st_nxt.count = st_r.count - COUNT_STEP;
					end else begin
						st_nxt.count = st_r.count + COUNT_STEP;
					end
				end
				default: st_nxt.count = st_r.count;
			endcase
		end
		// Capture from the neighbouring unit
		if (capture_load) begin
			st_nxt.cap = st_r.count;
		end
		// Reads: low byte of count or capture snapshots the high byte
		if (io_rd) begin
			case (io_addr)
				ADDR_CTRL_A: st_nxt.rdata = {6'h00, st_r.ctl_a};
				ADDR_CTRL_B: st_nxt.rdata = {3'h0, st_r.ctl_b};
				ADDR_CNT_LO: begin
					st_nxt.rdata = st_r.count[7:0];
					st_nxt.temp = st_r.count[15:8];
				end
				ADDR_CNT_HI: st_nxt.rdata = st_r.temp;
				ADDR_CMPA_LO: st_nxt.rdata = st_r.cmp_a[7:0];
				ADDR_CMPA_HI: st_nxt.rdata = st_r.cmp_a[15:8];
				ADDR_CMPB_LO: st_nxt.rdata = st_r.cmp_b[7:0];
				ADDR_CMPB_HI: st_nxt.rdata = st_r.cmp_b[15:8];
				ADDR_CAP_LO: begin
					st_nxt.rdata = st_r.cap[7:0];
					st_nxt.temp = st_r.cap[15:8];
				end
				ADDR_CAP_HI: st_nxt.rdata = st_r.temp;
				ADDR_STATUS: st_nxt.rdata = {7'h00, st_r.ovf};
				default: st_nxt.rdata = BYTE_RST;
			endcase
		end
		// Writes: high bytes park in the shared holding register
		if (io_wr) begin
			case (io_addr)
				ADDR_CTRL_A: st_nxt.ctl_a = io_wdata[1:0];
				ADDR_CTRL_B: st_nxt.ctl_b = io_wdata[4:0];
				ADDR_CNT_LO: st_nxt.count = {st_r.temp, io_wdata};
				ADDR_CMPA_LO: st_nxt.cmp_a = {st_r.temp, io_wdata};
				ADDR_CMPB_LO: st_nxt.cmp_b = {st_r.temp, io_wdata};
				ADDR_CAP_LO: st_nxt.cap = {st_r.temp, io_wdata};
				ADDR_CNT_HI, ADDR_CMPA_HI, ADDR_CMPB_HI, ADDR_CAP_HI: begin
					st_nxt.temp = io_wdata;
				end
				default: st_nxt.temp = st_nxt.temp;
			endcase
		end
		// Floor flag follows the new count
		st_nxt.floor = (st_nxt.count == COUNT_FLOOR);
	end

	// State register
	always_ff @(posedge clock) begin
		if (srst) begin
			st_r.ctl_a <= CTRL_A_RST;
			st_r.ctl_b <= CTRL_B_RST;
			st_r.count <= WORD_RST;
			st_r.cmp_a <= WORD_RST;
			st_r.cmp_b <= WORD_RST;
			st_r.cap <= WORD_RST;
			st_r.temp <= BYTE_RST;
			st_r.down <= 1'b0;
			st_r.ovf <= 1'b0;
			st_r.floor <= FLOOR_RST;
			st_r.rdata <= BYTE_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign io_rdata = st_r.rdata;
	assign count_value = st_r.count;
	assign compare_a_value = st_r.cmp_a;
	assign compare_b_value = st_r.cmp_b;
	assign capture_value = st_r.cap;
	assign count_floor = st_r.floor;
	assign overflow_flag = st_r.ovf;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (srst);

	property p_floor;
		count_floor == (count_value == COUNT_FLOOR);
	endproperty
	a_floor: assert property (p_floor)
		else $error("floor flag disagrees with count");

	property p_max_wrap;
		timer_tick && !cnt_wr && (waveform_mode_select == 4'h0) &&
			(count_value == COUNT_MAX) |=> (count_value == COUNT_FLOOR) && overflow_flag;
	endproperty
	a_max_wrap: assert property (p_max_wrap)
		else $error("normal mode did not wrap at full scale");

	property p_fixed_top;
		timer_tick && !cnt_wr && (waveform_mode_select == 4'h5) &&
			(count_value == TOP_8BIT) |=> (count_value == COUNT_FLOOR) && overflow_flag;
	endproperty
	a_fixed_top: assert property (p_fixed_top)
		else $error("fast mode did not clear at fixed ceiling");

	property p_low_write;
		cnt_wr |=> count_value == {$past(st_r.temp), $past(io_wdata)};
	endproperty
	a_low_write: assert property (p_low_write)
		else $error("low byte write did not load both bytes");

	property p_low_read;
		io_rd && !io_wr && (io_addr == ADDR_CNT_LO) |=>
			(st_r.temp == $past(count_value[15:8])) && (io_rdata == $past(count_value[7:0]));
	endproperty
	a_low_read: assert property (p_low_read)
		else $error("low byte read did not snapshot high byte");

	property p_cmp_read;
		io_rd && !io_wr && (io_addr == ADDR_CMPA_HI) |=>
			$stable(st_r.temp) && (io_rdata == $past(compare_a_value[15:8]));
	endproperty
	a_cmp_read: assert property (p_cmp_read)
		else $error("compare read touched holding register");

	property p_high_loc;
		io_wr && (io_addr == ADDR_CNT_HI) ##1 !io_wr && !io_rd ##1
			io_rd && !io_wr && (io_addr == ADDR_CNT_HI) |=> io_rdata == $past(io_wdata, 3);
	endproperty
	a_high_loc: assert property (p_high_loc)
		else $error("count high location bypassed holding register");

	property p_stopped;
		(clock_source_select == SRC_OFF) && !cnt_wr |=> $stable(count_value);
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("counter moved with no source");

	property p_step;
		timer_tick && !cnt_wr |=> (count_value == 16'($past(count_value) + COUNT_STEP)) ||
			(count_value == 16'($past(count_value) - COUNT_STEP)) ||
			(count_value == COUNT_FLOOR);
	endproperty
	a_step: assert property (p_step)
		else $error("count moved by other than one");

	property p_ovf_hold;
		!overflow_flag ##1 overflow_flag |-> $past(timer_tick) && !$past(cnt_wr);
	endproperty
	a_ovf_hold: assert property (p_ovf_hold)
		else $error("overflow set without a tick");

	c_wrap: cover property (timer_tick && (count_value == COUNT_MAX) ##1 overflow_flag);
	c_pair_write: cover property (io_wr && (io_addr == ADDR_CNT_HI) ##1 cnt_wr);
	c_turn: cover property (!st_r.down ##1 st_r.down);
	c_ext: cover property ((clock_source_select == SRC_EXT_RISE) && timer_tick);
endmodule

// File: tb/cpu_byte_master.sv
`timescale 1ns/1ns
module cpu_byte_master (
	// Clock
	input wire logic clock,
	// Byte bus towards the timer
	output logic [3:0] io_addr,
	output logic io_wr,
	output logic io_rd,
	output logic [7:0] io_wdata,
	// Registered read data
	input wire logic [7:0] io_rdata
);
	// ****************************************
	// Bus idle from time zero
	// ****************************************
	initial begin
		io_addr = 4'hF;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_wdata = 8'h00;
	end

	// Released data is inverted so a stale byte never passes for a fresh one
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		@(negedge clock);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		@(negedge clock);
		io_wr = 1'b0;
		io_wdata = ~d;
	endtask

	// Data is taken one edge after the strobe
	task automatic rd8(input logic [3:0] a, output logic [7:0] d);
		@(negedge clock);
		io_addr = a;
		io_rd = 1'b1;
		@(negedge clock);
		io_rd = 1'b0;
		d = io_rdata;
	endtask

	// High byte first, strobe held across both bytes so nothing slips between
	task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
		@(negedge clock);
		io_addr = lo + 4'h1;
		io_wdata = v[15:8];
		io_wr = 1'b1;
		@(negedge clock);
		io_addr = lo;
		io_wdata = v[7:0];
		@(negedge clock);
		io_wr = 1'b0;
		io_wdata = ~v[7:0];
	endtask

	// Low byte first, high byte in the very next cycle
	task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
		@(negedge clock);
		io_addr = lo;
		io_rd = 1'b1;
		@(negedge clock);
		v[7:0] = io_rdata;
		io_addr = lo + 4'h1;
		@(negedge clock);
		io_rd = 1'b0;
		v[15:8] = io_rdata;
	endtask
endmodule

// File: tb/sixteen_bit_counter_core_bench.sv
`timescale 1ns/1ns
module sixteen_bit_counter_core_bench;
	import counter_core_pkg::*;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic external_count_input = 1'b0;
	logic capture_load = 1'b0;
	logic [3:0] io_addr;
	logic io_wr, io_rd;
	logic [7:0] io_wdata, io_rdata;
	logic [15:0] count_value, compare_a_value, compare_b_value, capture_value;
	logic [3:0] waveform_mode_select;
	logic [2:0] clock_source_select;
	logic count_floor, overflow_flag;
	int n_fail = 0;
	int check_count = 0;
	int cycles = 0;
	logic [3:0] modes [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hE, 4'hF};
	logic [3:0] phases [7] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
	int shifts [5] = '{0, 3, 6, 8, 10};

	// ****************************************
	// Design, CPU model, clock and watchdog
	// ****************************************
	sixteen_bit_counter_core sixteen_bit_counter_core_i (.clock(clock), .srst(srst),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
		.io_rdata(io_rdata), .external_count_input(external_count_input),
		.capture_load(capture_load), .count_value(count_value),
		.compare_a_value(compare_a_value), .compare_b_value(compare_b_value),
		.capture_value(capture_value), .waveform_mode_select(waveform_mode_select),
		.clock_source_select(clock_source_select), .count_floor(count_floor),
		.overflow_flag(overflow_flag));
	cpu_byte_master cpu_byte_master_i (.clock(clock), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));

	always #10 clock = ~clock;

	// Whole run needs about 6000 cycles; twice that means a hang
	always @(posedge clock) begin
		cycles++;
		if (cycles == 12000) begin
			n_fail++;
			report_and_stop();
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Mode low bits live in control A, high bits beside the source in control B
	task automatic set_mode(input logic [3:0] m, input logic [2:0] s);
		cpu_byte_master_i.wr8(ADDR_CTRL_A, {6'h00, m[1:0]});
		cpu_byte_master_i.wr8(ADDR_CTRL_B, {3'h0, m[3:2], s});
	endtask

	// Ceiling per waveform mode used in the wrap checks
	function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] a,
		input logic [15:0] c);
		case (m)
			4'h1, 4'h5: return TOP_8BIT;
			4'h2, 4'h6: return TOP_9BIT;
			4'h3, 4'h7: return TOP_10BIT;
			4'h8, 4'hA, 4'hC, 4'hE: return c;
			default: return a;
		endcase
	endfunction

	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		logic [15:0] w, v, a, c;
		logic [7:0] b;
		int k;
		void'($urandom(40));
		repeat (4) @(negedge clock);
		srst = 1'b0;
		check(count_value, WORD_RST);
		check({15'h0000, count_floor}, {15'h0000, FLOOR_RST});
		check({15'h0000, overflow_flag}, 16'h0000);
		check({13'h0000, clock_source_select}, {13'h0000, SRC_OFF});
		$display("test reset done");
		// Corner words first, then random ones, counter stopped
		for (int i = 0; i < 10; i++) begin
			w = (i == 0) ? COUNT_FLOOR : (i == 1) ? COUNT_MAX : 16'($urandom);
			cpu_byte_master_i.wr16(ADDR_CNT_LO, w);
			repeat (3) @(negedge clock);
			check(count_value, w);
			check({15'h0000, count_floor}, {15'h0000, w == COUNT_FLOOR});
			cpu_byte_master_i.rd16(ADDR_CNT_LO, v);
			check(v, w);
		end
		$display("test words done");
		// Compare reads must leave the shared byte alone
		a = 16'($urandom);
		c = 16'($urandom);
		cpu_byte_master_i.wr16(ADDR_CMPA_LO, a);
		cpu_byte_master_i.wr16(ADDR_CNT_LO, c);
		cpu_byte_master_i.rd8(ADDR_CNT_LO, b);
		check({8'h00, b}, {8'h00, c[7:0]});
		cpu_byte_master_i.rd8(ADDR_CMPA_HI, b);
		check({8'h00, b}, {8'h00, a[15:8]});
		cpu_byte_master_i.rd8(ADDR_CNT_HI, b);
		check({8'h00, b}, {8'h00, c[15:8]});
		cpu_byte_master_i.wr8(ADDR_CMPB_HI, a[7:0]);
		cpu_byte_master_i.wr8(ADDR_CMPA_LO, c[15:8]);
		cpu_byte_master_i.wr8(ADDR_CMPB_LO, c[7:0]);
		check(compare_a_value, {a[7:0], c[15:8]});
		check(compare_b_value, {a[7:0], c[7:0]});
		capture_load = 1'b1;
		@(negedge clock);
		capture_load = 1'b0;
		cpu_byte_master_i.rd16(ADDR_CAP_LO, v);
		check(capture_value, c);
		check(v, c);
		// Unmapped locations read zero and leave the shared byte alone
		for (int u = 11; u < 16; u++) begin
			cpu_byte_master_i.wr8(4'(u), 8'hFF);
			cpu_byte_master_i.rd8(4'(u), b);
			check({8'h00, b}, 16'h0000);
		end
		cpu_byte_master_i.rd8(ADDR_CNT_HI, b);
		check({8'h00, b}, {8'h00, c[15:8]});
		cpu_byte_master_i.wr8(ADDR_CNT_HI, a[15:8]);
		cpu_byte_master_i.rd8(ADDR_CNT_HI, b);
		check({8'h00, b}, {8'h00, a[15:8]});
		$display("test holding_byte done");
		// CPU write lands on a ticking edge and must win
		set_mode(4'h0, SRC_DIRECT);
		w = 16'($urandom_range(16'hFF00, 16'h0000));
		cpu_byte_master_i.wr16(ADDR_CNT_LO, w);
		check(count_value, w);
		@(negedge clock);
		check(count_value, w + COUNT_STEP);
		set_mode(4'h0, SRC_OFF);
		cpu_byte_master_i.wr8(ADDR_STATUS, 8'h01);
		check({15'h0000, overflow_flag}, 16'h0000);
		cpu_byte_master_i.wr8(ADDR_CTRL_B, {5'h00, SRC_DIRECT});
		cpu_byte_master_i.wr16(ADDR_CNT_LO, COUNT_MAX - COUNT_STEP);
		@(negedge clock);
		check(count_value, COUNT_MAX);
		check({15'h0000, overflow_flag}, 16'h0000);
		@(negedge clock);
		check(count_value, COUNT_FLOOR);
		check({15'h0000, overflow_flag}, 16'h0001);
		cpu_byte_master_i.wr8(ADDR_CTRL_B, 8'h00);
		cpu_byte_master_i.wr8(ADDR_STATUS, 8'h01);
		check({15'h0000, overflow_flag}, 16'h0000);
		$display("test overflow done");
		// Start one below each ceiling and expect a clear right after it
		a = 16'($urandom_range(16'hFFF0, 16'h0400));
		c = 16'($urandom_range(16'hFFF0, 16'h0400));
		cpu_byte_master_i.wr16(ADDR_CMPA_LO, a);
		cpu_byte_master_i.wr16(ADDR_CAP_LO, c);
		foreach (modes[i]) begin
			set_mode(modes[i], SRC_DIRECT);
			check({12'h000, waveform_mode_select}, {12'h000, modes[i]});
			w = top_of(modes[i], a, c);
			cpu_byte_master_i.wr16(ADDR_CNT_LO, w - COUNT_STEP);
			@(negedge clock);
			check(count_value, w);
			@(negedge clock);
			check(count_value, COUNT_FLOOR);
		end
		// Phase modes at their ceiling must come back down whatever the direction
		foreach (phases[i]) begin
			set_mode(phases[i], SRC_DIRECT);
			w = top_of(phases[i], a, c);
			cpu_byte_master_i.wr16(ADDR_CNT_LO, w);
			@(negedge clock);
			check(count_value, w - COUNT_STEP);
			@(negedge clock);
			check(count_value, w - 16'h0002);
		end
		$display("test ceilings done");
		// Exactly 1024 cycles with each internal source enabled
		for (int s = 1; s <= 5; s++) begin
			set_mode(4'h0, SRC_OFF);
			cpu_byte_master_i.wr16(ADDR_CNT_LO, COUNT_FLOOR);
			cpu_byte_master_i.wr8(ADDR_CTRL_B, {5'h00, 3'(s)});
			repeat (1022) @(negedge clock);
			cpu_byte_master_i.wr8(ADDR_CTRL_B, 8'h00);
			repeat (3) @(negedge clock);
			check(count_value, 16'(1024 >> shifts[s - 1]));
		end
		$display("test prescaler done");
		// Slow pin pulses; one tick per chosen edge
		for (int e = 0; e < 2; e++) begin
			cpu_byte_master_i.wr16(ADDR_CNT_LO, COUNT_FLOOR);
			cpu_byte_master_i.wr8(ADDR_CTRL_B, {5'h00, e ? SRC_EXT_FALL : SRC_EXT_RISE});
			k = $urandom_range(12, 1);
			repeat (k) begin
				repeat (3) @(negedge clock);
				external_count_input = 1'b1;
				repeat (3) @(negedge clock);
				external_count_input = 1'b0;
			end
			repeat (8) @(negedge clock);
			check(count_value, 16'(k));
			cpu_byte_master_i.wr8(ADDR_CTRL_B, 8'h00);
		end
		$display("test external done");
		report_and_stop();
	end
endmodule
